// ---- verilog/usdr_defs.svh ----
// Register offsets, field positions, reset values and counts for the UART.
`ifndef USDR_DEFS_SVH
`define USDR_DEFS_SVH

`define USDR_OFF_MODE       8'h00
`define USDR_OFF_STA        8'h04
`define USDR_OFF_TXD        8'h08
`define USDR_OFF_RXD        8'h0C
`define USDR_OFF_BRG        8'h10

`define USDR_MODE_INFRARED_CODEC_ENABLE      12
`define USDR_MODE_HIGH_SPEED_BAUD_SELECT      3
`define USDR_MODE_PD_HI     2
`define USDR_MODE_PD_LO     1
`define USDR_MODE_STOP_BIT_COUNT_SELECT     0
`define USDR_MODE_WMASK     16'h100F
`define USDR_MODE_RESET     16'h0000

`define USDR_STA_TXI1       15
`define USDR_STA_TXINV      14
`define USDR_STA_TXI0       13
`define USDR_STA_BRK        11
`define USDR_STA_TXEN       10
`define USDR_STA_TXBF       9
`define USDR_STA_TX_SHIFT_EMPTY       8
`define USDR_STA_RXI_HI     7
`define USDR_STA_RXI_LO     6
`define USDR_STA_ADDRESS_DETECT_ENABLE      5
`define USDR_STA_RX_IDLE_FLAG      4
`define USDR_STA_PARITY_ERROR_FLAG       3
`define USDR_STA_FRAMING_ERROR_FLAG       2
`define USDR_STA_RX_OVERRUN_FLAG       1
`define USDR_STA_RXDA       0
`define USDR_STA_WMASK      16'hECE0
`define USDR_STA_RESET      16'h0000
`define USDR_BRG_RESET      16'h0000

`define USDR_PD_9N          2'b11
`define USDR_PD_8O          2'b10
`define USDR_PD_8E          2'b01
`define USDR_PD_8N          2'b00
`define USDR_TXI_ANY        2'b00
`define USDR_TXI_EMPTY      2'b10
`define USDR_TXI_DONE       2'b01
`define USDR_RXI_FULL       2'b11
`define USDR_RXI_3Q         2'b10

`define USDR_CLK_PER_BIT_HI  4
`define USDR_CLK_PER_BIT_STD 16
`define USDR_BRK_ZEROS      12
`define USDR_RX_DEPTH       4
`define USDR_RX_LEVEL       3
`define USDR_RESP_OKAY      2'b00
`define USDR_RESP_SLVERR    2'b10

`endif

// ---- verilog/usdr_pkg.sv ----
// Types shared by the serial transceiver modules.
package usdr_pkg;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP}
        usdr_rx_state_type;

    typedef struct packed {
        logic       framing_error_flag;
        logic       parity_error_flag;
        logic [8:0] data;
    } usdr_rx_word_type;

    typedef struct packed {
        usdr_rx_word_type [3:0] mem;
        logic [1:0]             wp;
        logic [1:0]             rp;
        logic [2:0]             cnt;
        usdr_rx_word_type       head;
    } usdr_mem_state_type;

    typedef struct packed {
        logic [15:0]       mode;
        logic [15:0]       ctl;
        logic [15:0]       baud_generator;
        logic              rx_overrun_flag;
        logic              hold_v;
        logic [8:0]        hold;
        logic              busy;
        logic              brk_fr;
        logic [15:0]       frame;
        logic [3:0]        tcnt;
        logic              line;
        logic [3:0]        tx_sub;
        logic [15:0]       brg_cnt;
        logic [1:0]        en_pipe;
        usdr_rx_state_type rxst;
        logic [3:0]        rx_sub;
        logic [3:0]        rx_bit;
        logic [8:0]        rx_sh;
        logic              tx_irq;
        logic              rx_irq;
        logic              tx_pin;
        logic              tx_oe;
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [31:0]       rdata;
        logic              aw_got;
        logic [7:0]        aw_addr;
        logic              w_got;
        logic [15:0]       w_data;
        logic [1:0]        w_strb;
    } usdr_state_type;

endpackage

// ---- verilog/usdr_rxq_if.sv ----
// Link between the receive logic and its character queue.
`timescale 1ns/1ns
`default_nettype none
interface usdr_rxq_if;
    logic                        push;
    usdr_pkg::usdr_rx_word_type  wdata;
    logic                        pop;
    logic                        flush;
    logic [2:0]                  cnt;
    usdr_pkg::usdr_rx_word_type  head;
    modport ctl (output push, wdata, pop, flush, input cnt, head);
    modport mem (input push, wdata, pop, flush, output cnt, head);
endinterface
`default_nettype wire

// ---- verilog/usdr_rx_mem.sv ----
// Four-entry receive character queue with a registered head word.
`timescale 1ns/1ns
`default_nettype none
`include "usdr_defs.svh"
module usdr_rx_mem
(
    input  wire logic  aclk,
    input  wire logic  aresetn,
    usdr_rxq_if.mem    q
);
    import usdr_pkg::*;

    usdr_mem_state_type s;
    usdr_mem_state_type n;
    logic               put;
    logic               take;

    // Flush beats push and pop; the head is read from the next state so that
    // count and head always describe the same entry.
    always_comb
    begin
        n = s;
        put = q.push && (s.cnt != 3'(`USDR_RX_DEPTH));
        take = q.pop && (s.cnt != 3'h0);
        if (q.flush)
        begin
            n.wp = 2'h0;
            n.rp = 2'h0;
            n.cnt = 3'h0;
        end
        else
        begin
            if (put)
            begin
                n.mem[s.wp] = q.wdata;
                n.wp = s.wp + 2'h1;
            end
            if (take)
                n.rp = s.rp + 2'h1;
            n.cnt = s.cnt + {2'h0, put} - {2'h0, take};
        end
        n.head = n.mem[n.rp];
    end

    // Synchronous reset empties the queue.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s <= '0;
        else
            s <= n;
    end

    assign q.cnt = s.cnt;
    assign q.head = s.head;
endmodule
`default_nettype wire

// ---- verilog/usdr_uart.sv ----
// Serial transceiver with mode, status and data registers on AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "usdr_defs.svh"

// How it works
// RL1 - Fast baud select gives 4, else 16
// RL2 - Parity field picks width and parity
// RL3 - Stop select sends two or one stops
// RL4 - Transmit interrupt follows its mode field
// RL5 - Polarity bit sets idle level, codec flips
// RL6 - Break sends start, twelve zeros, stop
// RL7 - Transmit enable drives pin; clearing aborts
// RL8 - Buffer full flag when no free slot
// RL9 - Shift empty when nothing queued or sending
// RL10 - Receive interrupt at full, three, any
// RL11 - Address detect only in nine-bit mode
// RL12 - Receiver idle flag low while receiving
// RL13 - Parity error belongs to head character
// RL14 - Framing error belongs to head character
// RL15 - Overrun sets; clearing empties receive path
// RL16 - Data available while queue not empty
// RL17 - Transmit word takes nine data bits
// RL18 - Receive word gives head, upper zero
// RL19 - Reading receive word advances the queue
// RL20 - Bit rate is clock over (divisor+1) times 4 or 16
// RL21 - Enabling transmit interrupts two cycles later
// RL22 - Frame: start, data LSB first, parity, stops
module usdr_uart
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        rx_in,
    output logic             tx_out,
    output logic             tx_oe,
    output logic             tx_irq,
    output logic             rx_irq
);
    import usdr_pkg::*;

    usdr_state_type   s;
    usdr_state_type   n;
    usdr_rx_word_type word;
    logic [15:0] sta_rd;
    logic [15:0] wd;
    logic [7:0]  wa;
    logic [1:0]  ws;
    logic [3:0]  sub_last;
    logic [3:0]  rx_last;
    logic [1:0]  pd;
    logic        txen;
    logic        sub_tick;
    logic        bit_tick;
    logic        last;
    logic        brk_end;
    logic        brk_now;
    logic        xfer;
    logic        done;
    logic        tx_ev;
    logic        aw_ok;
    logic        w_ok;
    logic        wr_go;
    logic        wr_tx;
    logic        push;
    logic        keep;
    logic        ovf;
    logic        rx_overrun_flag_clr;
    logic        rx_ev;

    usdr_rxq_if q ();

    usdr_rx_mem u_rx_mem
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .q       (q.mem)
    );

    // Index of the last baud sub-tick within one bit.
    function automatic logic [3:0] bit_last(input logic hi, input logic half);
        logic [4:0] per;
        per = hi ? 5'(`USDR_CLK_PER_BIT_HI) : 5'(`USDR_CLK_PER_BIT_STD);
        if (half)
            per = per >> 1;
        return 4'(per - 5'h1);
    endfunction

    // Builds a line frame, bit 0 first, with its length in the top nibble.
    function automatic logic [19:0] tx_frame(input logic [8:0] d,
        input logic [1:0] p, input logic st, input logic brk);
        logic [15:0] f;
        logic [3:0]  len;
        f = 16'hFFFF;
        if (brk)
        begin
            f[`USDR_BRK_ZEROS:0] = '0;
            len = 4'(`USDR_BRK_ZEROS + 2);
        end
        else
        begin
            f[0] = 1'b0;
            f[8:1] = d[7:0];
            if (p == `USDR_PD_9N)
                f[9] = d[8];
            else if (p == `USDR_PD_8E)
                f[9] = ^d[7:0];
            else if (p == `USDR_PD_8O)
                f[9] = ~^d[7:0];
            len = (p == `USDR_PD_8N) ? 4'h9 : 4'hA;
            len = len + (st ? 4'h2 : 4'h1);
        end
        return {len, f};
    endfunction

    // Byte-lane merge of a 16-bit register under its writable mask.
    function automatic logic [15:0] merge(input logic [15:0] o,
        input logic [15:0] d, input logic [1:0] st, input logic [15:0] m);
        logic [15:0] be;
        be = {{8{st[1]}}, {8{st[0]}}} & m;
        return (o & ~be) | (d & be);
    endfunction

    // Only the five register words answer OKAY.
    function automatic logic addr_ok(input logic [7:0] a);
        return (a[7:2] <= `USDR_OFF_BRG >> 2);
    endfunction

    // Status word as software sees it; parity and framing error bits come from the head entry.
    always_comb
    begin
        sta_rd = s.ctl;
        sta_rd[`USDR_STA_TXBF] = s.hold_v;                    // [RL8]
        sta_rd[`USDR_STA_TX_SHIFT_EMPTY] = !s.busy && !s.hold_v;        // [RL9]
        sta_rd[`USDR_STA_RX_IDLE_FLAG] = (s.rxst == RX_IDLE);        // [RL12]
        sta_rd[`USDR_STA_PARITY_ERROR_FLAG] = q.head.parity_error_flag && (q.cnt != 3'h0); // [RL13]
        sta_rd[`USDR_STA_FRAMING_ERROR_FLAG] = q.head.framing_error_flag && (q.cnt != 3'h0); // [RL14]
        sta_rd[`USDR_STA_RX_OVERRUN_FLAG] = s.rx_overrun_flag;
        sta_rd[`USDR_STA_RXDA] = (q.cnt != 3'h0);             // [RL16]
    end

    // Whole next-state computation: decode, baud, transmit, receive, bus.
    always_comb
    begin
        n = s;
        pd = s.mode[`USDR_MODE_PD_HI:`USDR_MODE_PD_LO];
        txen = s.ctl[`USDR_STA_TXEN];
        // Write address and data may arrive in either order.
        aw_ok = s.aw_got || (s_axi_awvalid && s.awready);
        w_ok = s.w_got || (s_axi_wvalid && s.wready);
        wa = s.aw_got ? s.aw_addr : s_axi_awaddr;
        wd = s.w_got ? s.w_data : s_axi_wdata[15:0];
        ws = s.w_got ? s.w_strb : s_axi_wstrb[1:0];
        wr_go = aw_ok && w_ok && !s.bvalid;
        wr_tx = wr_go && (wa[7:2] == `USDR_OFF_TXD >> 2) && ws[0];

        // Divider gives a sub-tick every divisor+1 clocks.
        sub_tick = (s.brg_cnt == s.baud_generator);                          // [RL20]
        n.brg_cnt = sub_tick ? 16'h0000 : s.brg_cnt + 16'h0001;
        sub_last = bit_last(s.mode[`USDR_MODE_HIGH_SPEED_BAUD_SELECT], 1'b0);
        // The transmit bit clock restarts from zero while disabled.
        bit_tick = txen && sub_tick && (s.tx_sub == sub_last);    // [RL1]
        if (!txen)
            n.tx_sub = 4'h0;
        else if (sub_tick)
            n.tx_sub = (s.tx_sub == sub_last) ? 4'h0 : s.tx_sub + 4'h1;

        // Transmit shifter; a new frame loads on the bit edge that ends one.
        last = s.busy && (s.tcnt == 4'h1);
        brk_end = last && s.brk_fr;
        brk_now = s.ctl[`USDR_STA_BRK] && !brk_end;
        xfer = 1'b0;
        done = 1'b0;
        if (bit_tick)
        begin
            if (s.busy && !last)
            begin
                n.frame = {1'b1, s.frame[15:1]};                  // [RL22]
                n.tcnt = s.tcnt - 4'h1;
            end
            if (brk_end)
                n.ctl[`USDR_STA_BRK] = 1'b0;                      // [RL6]
            if ((!s.busy || last) && s.hold_v)
            begin
                {n.tcnt, n.frame} = tx_frame(s.hold, pd,          // [RL2]
                    s.mode[`USDR_MODE_STOP_BIT_COUNT_SELECT], brk_now);           // [RL3] [RL6]
                n.brk_fr = brk_now;
                n.busy = 1'b1;
                n.hold_v = 1'b0;
                xfer = 1'b1;
            end
            else if (last)
            begin
                n.busy = 1'b0;
                n.brk_fr = 1'b0;
                done = 1'b1;
            end
        end

        // Transmit interrupt source; a write in the same cycle refills.
        unique case ({s.ctl[`USDR_STA_TXI1], s.ctl[`USDR_STA_TXI0]})
            `USDR_TXI_ANY:   tx_ev = xfer;                        // [RL4]
            `USDR_TXI_EMPTY: tx_ev = xfer && !wr_tx;              // [RL4]
            `USDR_TXI_DONE:  tx_ev = done;                        // [RL4]
            default:         tx_ev = 1'b0;
        endcase

        // Receiver samples mid-bit; the start bit is checked at half a bit.
        rx_last = (pd == `USDR_PD_8N) ? 4'h7 : 4'h8;
        push = 1'b0;
        ovf = 1'b0;
        keep = 1'b0;
        word = '0;
        word.framing_error_flag = !rx_in;                                       // [RL14]
        word.parity_error_flag = (pd == `USDR_PD_8E) ? ^s.rx_sh :
                    (pd == `USDR_PD_8O) ? ~^s.rx_sh : 1'b0;       // [RL13]
        word.data = (pd == `USDR_PD_9N) ? s.rx_sh : {1'b0, s.rx_sh[7:0]};
        if (sub_tick)
            n.rx_sub = s.rx_sub + 4'h1;
        unique case (s.rxst)
            RX_IDLE:
                if (!rx_in)
                begin
                    n.rxst = RX_START;
                    n.rx_sub = 4'h0;
                end
            RX_START:
                if (sub_tick && s.rx_sub == bit_last(s.mode[3], 1'b1))
                begin
                    n.rx_sub = 4'h0;
                    n.rx_bit = 4'h0;
                    n.rxst = rx_in ? RX_IDLE : RX_DATA;
                end
            RX_DATA:
                if (sub_tick && s.rx_sub == sub_last)
                begin
                    n.rx_sub = 4'h0;
                    n.rx_sh[s.rx_bit] = rx_in;                    // [RL22]
                    n.rx_bit = s.rx_bit + 4'h1;
                    if (s.rx_bit == rx_last)
                        n.rxst = RX_STOP;
                end
            RX_STOP:
                if (sub_tick && s.rx_sub == sub_last)
                begin
                    n.rxst = RX_IDLE;
                    keep = !(s.ctl[`USDR_STA_ADDRESS_DETECT_ENABLE] &&             // [RL11]
                             pd == `USDR_PD_9N && !s.rx_sh[8]);
                    ovf = keep && (q.cnt == 3'(`USDR_RX_DEPTH));  // [RL15]
                    push = keep && !ovf;
                end
        endcase
        unique case (s.ctl[`USDR_STA_RXI_HI:`USDR_STA_RXI_LO])
            `USDR_RXI_FULL:
                rx_ev = push && (q.cnt == 3'(`USDR_RX_DEPTH - 1)); // [RL10]
            `USDR_RXI_3Q:
                rx_ev = push && (q.cnt == 3'(`USDR_RX_LEVEL - 1)); // [RL10]
            2'b00, 2'b01:
                rx_ev = push;                                     // [RL10]
        endcase

        // Register writes, applied after the hardware updates above.
        n.aw_got = aw_ok && !wr_go;
        n.w_got = w_ok && !wr_go;
        if (s_axi_awvalid && s.awready)
            n.aw_addr = s_axi_awaddr;
        if (s_axi_wvalid && s.wready)
        begin
            n.w_data = s_axi_wdata[15:0];
            n.w_strb = s_axi_wstrb[1:0];
        end
        if (s.bvalid && s_axi_bready)
            n.bvalid = 1'b0;
        rx_overrun_flag_clr = 1'b0;
        if (wr_go)
        begin
            n.bvalid = 1'b1;
            n.bresp = addr_ok(wa) ? `USDR_RESP_OKAY : `USDR_RESP_SLVERR;
            if (wa[7:2] == `USDR_OFF_MODE >> 2)
                n.mode = merge(s.mode, wd, ws, `USDR_MODE_WMASK);
            if (wa[7:2] == `USDR_OFF_BRG >> 2)
                n.baud_generator = merge(s.baud_generator, wd, ws, 16'hFFFF);
            if (wa[7:2] == `USDR_OFF_STA >> 2)
            begin
                n.ctl = merge(n.ctl, wd, ws, `USDR_STA_WMASK);
                rx_overrun_flag_clr = ws[0] && !wd[`USDR_STA_RX_OVERRUN_FLAG] && s.rx_overrun_flag; // [RL15]
            end
        end
        if (wr_tx && !n.hold_v)
        begin
            n.hold_v = 1'b1;
            n.hold = wd[8:0];                                     // [RL17]
        end
        // Dropping transmit enable aborts the frame and empties the buffer.
        if (txen && !n.ctl[`USDR_STA_TXEN])
        begin
            n.hold_v = 1'b0;                                      // [RL7]
            n.busy = 1'b0;
            n.brk_fr = 1'b0;
        end
        n.en_pipe = {s.en_pipe[0], !txen && n.ctl[`USDR_STA_TXEN]};
        // An overrun in the clearing cycle keeps the flag and the data.
        n.rx_overrun_flag = (s.rx_overrun_flag && !rx_overrun_flag_clr) || ovf;                    // [RL15]
        if (rx_overrun_flag_clr && !ovf)
            n.rxst = RX_IDLE;

        // Reads; a receive word read moves the next entry to the head.
        q.pop = 1'b0;
        if (s.rvalid && s_axi_rready)
            n.rvalid = 1'b0;
        if (s_axi_arvalid && s.arready)
        begin
            n.rvalid = 1'b1;
            n.rresp = addr_ok(s_axi_araddr) ? `USDR_RESP_OKAY
                                            : `USDR_RESP_SLVERR;
            unique case (s_axi_araddr[7:2])
                `USDR_OFF_MODE >> 2: n.rdata = {16'h0000, s.mode};
                `USDR_OFF_STA >> 2:  n.rdata = {16'h0000, sta_rd};
                `USDR_OFF_BRG >> 2:  n.rdata = {16'h0000, s.baud_generator};
                `USDR_OFF_RXD >> 2:
                begin
                    n.rdata = (q.cnt != 3'h0) ?
                        {23'h000000, q.head.data} : 32'h00000000; // [RL18]
                    q.pop = (q.cnt != 3'h0);                      // [RL19]
                end
                default:             n.rdata = 32'h00000000;
            endcase
        end
        n.awready = !n.aw_got && !n.bvalid;
        n.wready = !n.w_got && !n.bvalid;
        n.arready = !n.rvalid;

        // Pin and interrupt flops.
        n.line = n.busy ? n.frame[0] : 1'b1;
        n.tx_oe = n.ctl[`USDR_STA_TXEN];                          // [RL7]
        n.tx_pin = n.line ^ n.ctl[`USDR_STA_TXINV] ^             // [RL5]
                   n.mode[`USDR_MODE_INFRARED_CODEC_ENABLE];
        n.tx_irq = tx_ev || s.en_pipe[1];                         // [RL21]
        n.rx_irq = rx_ev;
        q.push = push;
        q.wdata = word;
        q.flush = rx_overrun_flag_clr && !ovf;                               // [RL15]
    end

    // Synchronous reset: all control, status and bus state to zero.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s <= '0;
        else
            s <= n;
    end

    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bresp = s.bresp;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_arready = s.arready;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign s_axi_rvalid = s.rvalid;
    assign tx_out = s.tx_pin;
    assign tx_oe = s.tx_oe;
    assign tx_irq = s.tx_irq;
    assign rx_irq = s.rx_irq;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    baud_ratio_a: assert property (bit_tick |->   // [RL1]
        s.tx_sub == (s.mode[`USDR_MODE_HIGH_SPEED_BAUD_SELECT] ? 4'h3 : 4'hF))
        else $error("bit period is not 4 or 16 sub-ticks");
    even_parity_a: assert property (xfer && !brk_now && pd == 2'b01 // [RL2]
        |=> ^s.frame[9:1] == 1'b0)
        else $error("even parity frame has odd weight");
    stop_count_a: assert property (xfer && !brk_now && pd == 2'b00 // [RL3]
        |=> s.tcnt == (s.mode[0] ? 4'hB : 4'hA))
        else $error("frame length ignores stop select");
    break_clear_a: assert property ($fell(s.ctl[`USDR_STA_BRK]) && // [RL6]
        !$past(wr_go) |-> $past(brk_end))
        else $error("break bit cleared before break ended");
    txen_irq_a: assert property ($rose(s.ctl[`USDR_STA_TXEN]) // [RL21]
        |-> ##2 s.tx_irq)
        else $error("no transmit interrupt two cycles after enable");
    buf_full_a: assert property (wr_tx && !s.hold_v // [RL8]
        |=> sta_rd[`USDR_STA_TXBF] && !sta_rd[`USDR_STA_TX_SHIFT_EMPTY])
        else $error("buffer flags wrong after transmit write");
    overrun_flush_a: assert property (rx_overrun_flag_clr && !ovf // [RL15]
        |=> q.cnt == 3'h0 && s.rxst == RX_IDLE && !s.rx_overrun_flag)
        else $error("overrun clear did not empty receive path");
    rx_avail_a: assert property (push && q.cnt == 3'h0 && !q.flush // [RL16]
        |=> sta_rd[`USDR_STA_RXDA])
        else $error("data available missing after push");
    rx_irq_a: assert property (s.rx_irq |-> $past(push)) // [RL10]
        else $error("receive interrupt without a transfer");
endmodule
`default_nettype wire

// ---- dv/usdr_remote.sv ----
// Remote serial device model that sends frames toward the receiver.
`timescale 1ns/1ns
`default_nettype none
module usdr_remote
#(
    parameter int BIT = 4
)
(
    input  wire logic aclk,
    output logic      line
);
    initial line = 1'b1;

    // Each level is held for whole bit times so the receiver sees clean bits.
    task automatic send(input logic [7:0] d);
        int i;
        @(posedge aclk);
        line <= 1'b0;
        repeat (BIT) @(posedge aclk);
        for (i = 0; i < 8; i++)
        begin
            line <= d[i];
            repeat (BIT) @(posedge aclk);
        end
        line <= 1'b1;
        repeat (BIT) @(posedge aclk);
    endtask
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking bench for the serial transceiver register block.
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic [7:0]  awaddr, araddr, rxc;
    logic [31:0] wdata, rdata, got;
    logic [1:0]  bresp, rresp, rsp;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
    logic        bready, arvalid, arready, rvalid, rready, rx_line;
    logic        tx_out, tx_oe, tx_irq, rx_irq;
    int          fails, cmp_count, tx_irqs, rx_irqs;

    usdr_uart DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .rx_in(rx_line), .tx_out(tx_out),
        .tx_oe(tx_oe), .tx_irq(tx_irq), .rx_irq(rx_irq));
    usdr_remote #(.BIT(4)) P (.aclk(aclk), .line(rx_line));

    // Pulses last one cycle, so they are counted as they pass.
    always @(posedge aclk)
    begin
        if (tx_irq === 1'b1) tx_irqs++;
        if (rx_irq === 1'b1) rx_irqs++;
    end

    task automatic chk(input string nm, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e)
        begin
            $display("BAD %s exp %h got %h", nm, e, g);
            fails++;
        end
    endtask

    // Address and data are offered together; each drops once it is taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        bready <= 1'b0;
        chk("wr_resp", 2'b00, bresp);
        // One idle edge keeps the next call from driving bready twice at once.
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        rready <= 1'b0;
        got = rdata;
        rsp = rresp;
        @(posedge aclk);
    endtask

    task automatic t_reset;
        rd(8'h04);
        chk("status", 32'h0110, got);
        rd(8'h14);
        chk("unmapped_resp", 2'b10, rsp);
        wr(8'h00, 32'h0008);
        rd(8'h00);
        chk("mode", 32'h0008, got);
        $display("test reset done");
    endtask

    task automatic t_rx;
        P.send(8'hA5);
        rd(8'h04);
        chk("status_rx", 32'h0111, got);
        chk("rx_irq", 1, rx_irqs);
        rd(8'h0C);
        chk("rx_word", 32'h00A5, got);
        rd(8'h04);
        chk("status_pop", 32'h0110, got);
        $display("test receive done");
    endtask

    // Five characters into a four-deep queue; clearing the flag empties it.
    task automatic t_ovf;
        int i;
        for (i = 0; i < 5; i++)
            P.send(8'h5A);
        rd(8'h04);
        chk("status_ovf", 32'h0113, got);
        chk("rx_irq_ovf", 5, rx_irqs);
        wr(8'h04, 32'h0000);
        rd(8'h04);
        chk("status_clr", 32'h0110, got);
        $display("test overrun done");
    endtask

    // The line is sampled near mid-bit after the falling start edge.
    task automatic t_tx;
        int i;
        wr(8'h04, 32'h0400);
        chk("tx_oe", 1'b1, tx_oe);
        chk("idle", 1'b1, tx_out);
        // The pulse lands two edges after the write and is counted one later.
        repeat (2) @(posedge aclk);
        chk("tx_irq", 1, tx_irqs);
        wr(8'h08, 32'h0135);
        for (i = 0; i < 200 && tx_out !== 1'b0; i++) @(posedge aclk);
        @(posedge aclk);
        for (i = 0; i < 8; i++)
        begin
            repeat (4) @(posedge aclk);
            rxc[i] = tx_out;
        end
        repeat (4) @(posedge aclk);
        chk("tx_char", 8'h35, rxc);
        chk("stop", 1'b1, tx_out);
        $display("test transmit done");
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    initial
    begin
        repeat (20000) @(posedge aclk);
        fails++;
        stop_test;
    end

    initial
    begin
        {awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
        {arvalid, rready, fails, cmp_count, tx_irqs, rx_irqs} = '0;
        aresetn = 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset;
        t_rx;
        t_ovf;
        t_tx;
        stop_test;
    end
endmodule
`default_nettype wire
